/* hdlc_rx_map.vh */
// Register offsets, field positions, reset values and counts of the receive HDLC status block
`ifndef HDLC_RX_MAP_VH
`define HDLC_RX_MAP_VH

// Register offsets on the parallel control port
`define OFS_HDLC_STATUS_FLAGS 8'hb1
`define OFS_HDLC_IRQ_ENABLE_MASK 8'hb2
`define OFS_HDLC_RX_PACKET_INFO 8'hb3
`define OFS_HDLC_RX_FIFO_DATA 8'hb4

// Status flag and mask positions
`define BIT_RX_PACKET_END 6
`define BIT_RX_PACKET_START 5
`define BIT_RX_FIFO_HALF_FULL 4
`define BIT_RX_FIFO_NOT_EMPTY 3
`define BIT_TX_FIFO_HALF_EMPTY 2
`define BIT_TX_FIFO_NOT_FULL 1
`define BIT_TX_MESSAGE_DONE 0

// Receive information positions
`define BIT_RX_ABORT_SEEN 7
`define BIT_RX_FCS_ERROR 6
`define BIT_RX_FIFO_OVERRUN 5
`define BIT_RX_VALID_MESSAGE 4
`define BIT_RX_FIFO_EMPTY_LIVE 3
`define BIT_LAST_BYTE_OF_GOOD_PACKET 2
`define BIT_LAST_BYTE_OF_PACKET 1
`define BIT_FIRST_BYTE_OF_PACKET 0

// Reset values
`define RST_IRQ_ENABLE_MASK 7'h00
`define RST_READ_DATA 8'h00

// Counts
`define RX_FIFO_DEPTH 64
`define RX_FIFO_HALF 32
`define ABORT_ONES 7

`endif

/* hdlc_byte_skid.v */
// Two-entry valid/ready buffer in the received byte path
`default_nettype none

module hdlc_byte_skid #(
	parameter W = 11
) (
	// Clock and reset
	input wire clk_i,
	input wire arst_n_i,
	// Filling side
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [W-1:0] in_data_i,
	// Draining side
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [W-1:0] out_data_o
);

reg [W-1:0] slot0;
reg [W-1:0] slot1;
reg [1:0] count;
wire push;
wire pop;

// Ready while a slot is free; drain side stall fills both slots
assign in_ready_o = (count != 2'd2);
assign out_valid_o = (count != 2'd0);
assign out_data_o = slot0;
assign push = in_valid_i & in_ready_o;
assign pop = out_valid_o & out_ready_i;

// Slot 0 always holds the oldest word
always @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		slot0 <= {W{1'b0}};
		slot1 <= {W{1'b0}};
		count <= 2'd0;
	end else begin
		if (pop) begin
			slot0 <= (count == 2'd2) ? slot1 : in_data_i;
			if (push && count == 2'd2)
				slot1 <= in_data_i;
		end else if (push) begin
			if (count == 2'd0)
				slot0 <= in_data_i;
			else
				slot1 <= in_data_i;
		end
		count <= count + {1'b0, push} - {1'b0, pop};
	end
end

endmodule // hdlc_byte_skid

`default_nettype wire

/* hdlc_rx_status.v */
// Receive HDLC status, interrupt mask and receive FIFO read port
`default_nettype none
`include "hdlc_rx_map.vh"

module hdlc_rx_status #(
	parameter DEPTH = `RX_FIFO_DEPTH,
	parameter HALF = `RX_FIFO_HALF,
	parameter AW = 6
) (
	// Clock and reset
	input wire CLK_I,
	input wire ARST_N_I,
	// Host register port, same clock
	input wire [7:0] ADDR_I,
	input wire WR_I,
	input wire RD_I,
	input wire [7:0] WDATA_I,
	output reg [7:0] RDATA_O,
	// Receive bit tap for abort detection
	input wire RX_BIT_I,
	input wire RX_BIT_STB_I,
	// Receive byte stream from the deframer
	input wire RX_BYTE_VLD_I,
	output wire RX_BYTE_RDY_O,
	input wire [7:0] RX_BYTE_I,
	input wire RX_FIRST_I,
	input wire RX_LAST_I,
	input wire RX_FCS_OK_I,
	// Transmit side status inputs
	input wire TX_HALF_EMPTY_I,
	input wire TX_NOT_FULL_I,
	input wire TX_MSG_DONE_I,
	// Masked status request
	output wire HDLC_IRQ_O
);

////////////////////////////////////////////////////////////////////////////////
// Declarations

localparam EW = 11;

reg [6:0] hdlc_irq_enable_mask;
reg rx_packet_end;
reg rx_packet_start;
reg tx_message_done;
reg rx_abort_seen;
reg rx_fcs_error;
reg rx_fifo_overrun;
reg rx_valid_message;
reg [2:0] ones_run;
reg pkt_bad;
reg [EW-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] fill;

wire skid_in_ready;
wire skid_out_valid;
wire [EW-1:0] skid_out_data;
wire [EW-1:0] skid_in_data;
wire fifo_full;
wire fifo_push;
wire fifo_pop;
wire [EW-1:0] head;
wire rx_fifo_empty_live;
wire rx_fifo_not_empty;
wire rx_fifo_half_full;
wire byte_taken;
wire overrun_now;
wire abort_now;
wire good_in;
wire rd_status;
wire rd_info;
wire rd_data;
wire wr_mask;
wire [6:0] hdlc_status_flags;
wire [7:0] hdlc_rx_packet_info;

////////////////////////////////////////////////////////////////////////////////
// Address decode

// Shared by the read and write strobes
function hit;
	input [7:0] addr;
	input [7:0] ofs;
	begin
		hit = (addr == ofs);
	end
endfunction

assign rd_status = RD_I & hit(ADDR_I, `OFS_HDLC_STATUS_FLAGS);
assign rd_info = RD_I & hit(ADDR_I, `OFS_HDLC_RX_PACKET_INFO);
assign rd_data = RD_I & hit(ADDR_I, `OFS_HDLC_RX_FIFO_DATA);
assign wr_mask = WR_I & hit(ADDR_I, `OFS_HDLC_IRQ_ENABLE_MASK);

////////////////////////////////////////////////////////////////////////////////
// Abort detection on the bit tap

// Saturating run of ones; pulse only on reaching the limit once per run
assign abort_now = RX_BIT_STB_I & RX_BIT_I & (ones_run == `ABORT_ONES - 1);

always @(posedge CLK_I or negedge ARST_N_I) begin
	if (!ARST_N_I) begin
		ones_run <= 3'd0;
	end else if (RX_BIT_STB_I) begin
		if (!RX_BIT_I)
			ones_run <= 3'd0;
		else if (ones_run != `ABORT_ONES)
			ones_run <= ones_run + 3'd1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Byte intake through the two-entry buffer

// A byte offered while the buffer is full is lost and flagged
assign byte_taken = RX_BYTE_VLD_I & skid_in_ready;
assign overrun_now = RX_BYTE_VLD_I & ~skid_in_ready;
assign RX_BYTE_RDY_O = skid_in_ready;

// Good closing byte: check passed, no abort or lost byte in the packet
assign good_in = RX_LAST_I & RX_FCS_OK_I & ~abort_now & (~pkt_bad | RX_FIRST_I);
assign skid_in_data = {good_in, RX_LAST_I, RX_FIRST_I, RX_BYTE_I};

// Packet damage tracker, reopened by every first byte
always @(posedge CLK_I or negedge ARST_N_I) begin
	if (!ARST_N_I) begin
		pkt_bad <= 1'b0;
	end else if (byte_taken && RX_LAST_I) begin
		pkt_bad <= 1'b0;
	end else if (byte_taken && RX_FIRST_I) begin
		pkt_bad <= abort_now;
	end else if (abort_now || overrun_now) begin
		pkt_bad <= 1'b1;
	end
end

hdlc_byte_skid #(
	.W(EW)
) u_skid (
	.clk_i(CLK_I),
	.arst_n_i(ARST_N_I),
	.in_valid_i(RX_BYTE_VLD_I),
	.in_ready_o(skid_in_ready),
	.in_data_i(skid_in_data),
	.out_valid_o(skid_out_valid),
	.out_ready_i(~fifo_full),
	.out_data_o(skid_out_data)
);

////////////////////////////////////////////////////////////////////////////////
// Receive FIFO, 64 entries of byte plus three tags

// Tags travel with the byte so the live bits follow the head entry
assign fifo_full = (fill == DEPTH);
assign fifo_push = skid_out_valid & ~fifo_full;
assign fifo_pop = rd_data & ~rx_fifo_empty_live;
assign head = mem[rd_ptr];
assign rx_fifo_empty_live = (fill == {(AW+1){1'b0}});
assign rx_fifo_not_empty = ~rx_fifo_empty_live;
assign rx_fifo_half_full = (fill > HALF);

// Storage has no reset; only pointers and the fill count need a defined value
always @(posedge CLK_I) begin
	if (fifo_push)
		mem[wr_ptr] <= skid_out_data;
end

always @(posedge CLK_I or negedge ARST_N_I) begin
	if (!ARST_N_I) begin
		wr_ptr <= {AW{1'b0}};
		rd_ptr <= {AW{1'b0}};
		fill <= {(AW+1){1'b0}};
	end else begin
		if (fifo_push)
			wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
		if (fifo_pop)
			rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
		fill <= fill + {{AW{1'b0}}, fifo_push} - {{AW{1'b0}}, fifo_pop};
	end
end

////////////////////////////////////////////////////////////////////////////////
// Mask register

always @(posedge CLK_I or negedge ARST_N_I) begin
	if (!ARST_N_I) begin
		hdlc_irq_enable_mask <= `RST_IRQ_ENABLE_MASK;
	end else if (wr_mask) begin
		hdlc_irq_enable_mask <= WDATA_I[6:0];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Latched status flags

// A new event in the clearing read cycle wins, so nothing is lost
always @(posedge CLK_I or negedge ARST_N_I) begin
	if (!ARST_N_I) begin
		rx_packet_end <= 1'b0;
		rx_packet_start <= 1'b0;
		tx_message_done <= 1'b0;
	end else begin
		if (byte_taken && RX_LAST_I || overrun_now || abort_now)
			rx_packet_end <= 1'b1;
		else if (rd_status)
			rx_packet_end <= 1'b0;
		if (byte_taken && RX_FIRST_I)
			rx_packet_start <= 1'b1;
		else if (rd_status)
			rx_packet_start <= 1'b0;
		if (TX_MSG_DONE_I)
			tx_message_done <= 1'b1;
		else if (rd_status)
			tx_message_done <= 1'b0;
	end
end

// Receive information flags, cleared by reading that register
always @(posedge CLK_I or negedge ARST_N_I) begin
	if (!ARST_N_I) begin
		rx_abort_seen <= 1'b0;
		rx_fcs_error <= 1'b0;
		rx_fifo_overrun <= 1'b0;
		rx_valid_message <= 1'b0;
	end else begin
		if (abort_now)
			rx_abort_seen <= 1'b1;
		else if (rd_info)
			rx_abort_seen <= 1'b0;
		if (byte_taken && RX_LAST_I && !RX_FCS_OK_I)
			rx_fcs_error <= 1'b1;
		else if (rd_info)
			rx_fcs_error <= 1'b0;
		if (overrun_now)
			rx_fifo_overrun <= 1'b1;
		else if (rd_info)
			rx_fifo_overrun <= 1'b0;
		if (byte_taken && good_in)
			rx_valid_message <= 1'b1;
		else if (rd_info)
			rx_valid_message <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read views and masked request

assign hdlc_status_flags = {
	rx_packet_end,
	rx_packet_start,
	rx_fifo_half_full,
	rx_fifo_not_empty,
	TX_HALF_EMPTY_I,
	TX_NOT_FULL_I,
	tx_message_done
};

// Head tags only count while a byte is actually presented
assign hdlc_rx_packet_info = {
	rx_abort_seen,
	rx_fcs_error,
	rx_fifo_overrun,
	rx_valid_message,
	rx_fifo_empty_live,
	head[10] & rx_fifo_not_empty,
	head[9] & rx_fifo_not_empty,
	head[8] & rx_fifo_not_empty
};

// A source reaches the request only if its mask bit is one
assign HDLC_IRQ_O = |(hdlc_status_flags & hdlc_irq_enable_mask);

// Read data registered one cycle after the strobe
always @(posedge CLK_I or negedge ARST_N_I) begin
	if (!ARST_N_I) begin
		RDATA_O <= `RST_READ_DATA;
	end else if (RD_I) begin
		if (hit(ADDR_I, `OFS_HDLC_STATUS_FLAGS))
			RDATA_O <= {1'b0, hdlc_status_flags};
		else if (hit(ADDR_I, `OFS_HDLC_IRQ_ENABLE_MASK))
			RDATA_O <= {1'b0, hdlc_irq_enable_mask};
		else if (hit(ADDR_I, `OFS_HDLC_RX_PACKET_INFO))
			RDATA_O <= hdlc_rx_packet_info;
		else if (hit(ADDR_I, `OFS_HDLC_RX_FIFO_DATA))
			RDATA_O <= rx_fifo_empty_live ? `RST_READ_DATA : head[7:0];
		else
			RDATA_O <= `RST_READ_DATA;
	end
end

endmodule // hdlc_rx_status

`default_nettype wire

/* hdlc_rx_status_props.sv */
// Concurrent checks on the receive HDLC status block ports
`default_nettype none
module hdlc_rx_status_props (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	// Host port
	input wire logic [7:0] ADDR_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [7:0] WDATA_I,
	input wire logic [7:0] RDATA_O,
	// Receive side
	input wire logic RX_BIT_I,
	input wire logic RX_BIT_STB_I,
	input wire logic RX_BYTE_VLD_I,
	input wire logic RX_BYTE_RDY_O,
	input wire logic RX_FIRST_I,
	// Status sources and request
	input wire logic TX_NOT_FULL_I,
	input wire logic HDLC_IRQ_O
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] mask;
	logic [2:0] ones;
	logic ovr, sop, abt;
	wire rd3 = RD_I && ADDR_I == 8'hb3;
	// Clearing read with no event in its cycle, else the event wins
	wire rd3_calm = rd3 && !RX_BYTE_VLD_I && !RX_BIT_STB_I;
	wire rd1 = RD_I && ADDR_I == 8'hb1;
	wire q = !RX_BYTE_VLD_I && !RX_BIT_STB_I && !RD_I && !WR_I;
	// Mirror of mask, run of ones and pending latched events
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			mask <= 7'h00;
			ones <= 3'h0;
			ovr <= 1'b0;
			sop <= 1'b0;
			abt <= 1'b0;
		end else begin
			if (WR_I && ADDR_I == 8'hb2) begin
				mask <= WDATA_I[6:0];
			end
			if (RX_BIT_STB_I) begin
				ones <= RX_BIT_I ? ones + {2'h0, ones != 3'h7} : 3'h0;
			end
			ovr <= (RX_BYTE_VLD_I && !RX_BYTE_RDY_O) || (ovr && !rd3);
			sop <= (RX_BYTE_VLD_I && RX_BYTE_RDY_O && RX_FIRST_I) || (sop && !rd1);
			// Seventh one lands on the same edge as the latched flag
			abt <= (RX_BIT_STB_I && RX_BIT_I && ones == 3'h6) || (abt && !rd3);
		end
	end
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!ARST_N_I);
	a_irq_all_masked: assert property (mask == 7'h00 |-> !HDLC_IRQ_O)
		else $error("request raised with every source masked");
	a_mask_read_back: assert property (RD_I && !WR_I && ADDR_I == 8'hb2 |=> RDATA_O == {1'b0, $past(mask)})
		else $error("mask read differs from written value");
	a_txnf_irq_follow: assert property ((mask[1] && TX_NOT_FULL_I) [*2] |-> HDLC_IRQ_O)
		else $error("enabled live source gives no request");
	a_info_read_clear: assert property (q [*3] ##1 rd3_calm ##1 q ##1 rd3 |=> RDATA_O[7:4] == 4'h0)
		else $error("latched info bits survive a read");
	a_overrun_latch: assert property (rd3 && ovr |=> RDATA_O[5])
		else $error("refused byte not shown as overrun");
	a_start_latch: assert property (rd1 && sop |=> RDATA_O[5])
		else $error("packet start not latched");
	a_abort_latch: assert property (rd3 && abt |=> RDATA_O[7])
		else $error("seven ones not shown as abort");
	a_rdata_hold: assert property (!RD_I |=> $stable(RDATA_O))
		else $error("read data moved without a read");
	a_good_is_last: assert property (rd3 |=> !RDATA_O[2] || RDATA_O[1])
		else $error("good packet flag on a byte that is not last");
endmodule // hdlc_rx_status_props
`default_nettype wire

/* hdlc_deframer_model.sv */
// Byte source standing in for the receive deframer
`default_nettype none
module hdlc_deframer_model (
	// Clock
	input wire logic clk_i,
	// Byte stream toward the status block
	input wire logic rdy_i,
	output logic vld_o,
	output logic [7:0] byte_o,
	output logic first_o,
	output logic last_o,
	output logic fcs_ok_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle lines at time zero
	initial begin
		vld_o = 1'b0;
		byte_o = 8'h00;
		first_o = 1'b0;
		last_o = 1'b0;
		fcs_ok_o = 1'b0;
	end
	// Rude mode ignores ready and moves on, so a refused byte is dropped, not offered again
	task automatic send(input logic [7:0] base, input int n, input logic ok, input logic rude);
		for (int i = 0; i < n; i++) begin
			vld_o <= 1'b1;
			byte_o <= base + i[7:0];
			first_o <= i == 0;
			last_o <= i == n - 1;
			fcs_ok_o <= ok;
			do @(posedge clk_i); while (!rude && !rdy_i);
		end
		// Released data shows the inverse, never a stale copy
		vld_o <= 1'b0;
		byte_o <= ~byte_o;
		first_o <= ~first_o;
		last_o <= ~last_o;
		fcs_ok_o <= ~fcs_ok_o;
	endtask
endmodule // hdlc_deframer_model
`default_nettype wire

/* hdlc_rx_status_tb_top.sv */
// Self-checking bench for the receive HDLC status block
`default_nettype none
module hdlc_rx_status_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK_I = 1'b0;
	logic ARST_N_I = 1'b0;
	logic [7:0] ADDR_I = 8'h00;
	logic WR_I = 1'b0;
	logic RD_I = 1'b0;
	logic [7:0] WDATA_I = 8'h00;
	logic RX_BIT_I = 1'b0;
	logic RX_BIT_STB_I = 1'b0;
	logic TX_HALF_EMPTY_I = 1'b0;
	logic TX_NOT_FULL_I = 1'b0;
	logic TX_MSG_DONE_I = 1'b0;
	wire RX_BYTE_VLD_I, RX_FIRST_I, RX_LAST_I, RX_FCS_OK_I, RX_BYTE_RDY_O, HDLC_IRQ_O;
	wire [7:0] RX_BYTE_I;
	wire [7:0] RDATA_O;
	int fails = 0;
	int samples_checked = 0;
	always #4 CLK_I = ~CLK_I;
	// Small FIFO so that filling it takes few cycles
	hdlc_rx_status #(.DEPTH(8), .HALF(4), .AW(3)) hdlc_rx_status_i (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
		.ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .RX_BIT_I(RX_BIT_I),
		.RX_BIT_STB_I(RX_BIT_STB_I), .RX_BYTE_VLD_I(RX_BYTE_VLD_I), .RX_BYTE_RDY_O(RX_BYTE_RDY_O),
		.RX_BYTE_I(RX_BYTE_I), .RX_FIRST_I(RX_FIRST_I), .RX_LAST_I(RX_LAST_I), .RX_FCS_OK_I(RX_FCS_OK_I),
		.TX_HALF_EMPTY_I(TX_HALF_EMPTY_I), .TX_NOT_FULL_I(TX_NOT_FULL_I), .TX_MSG_DONE_I(TX_MSG_DONE_I),
		.HDLC_IRQ_O(HDLC_IRQ_O));
	hdlc_deframer_model hdlc_deframer_model_i (.clk_i(CLK_I), .rdy_i(RX_BYTE_RDY_O), .vld_o(RX_BYTE_VLD_I),
		.byte_o(RX_BYTE_I), .first_o(RX_FIRST_I), .last_o(RX_LAST_I), .fcs_ok_o(RX_FCS_OK_I));
	////////////////////////////////////////////////////////////////
	task automatic chk_reg(input logic [7:0] a, e, g, m);
		samples_checked++;
		if ((g & m) !== (e & m)) begin
			fails++;
			$display("unexpected reg %h: expected %h seen %h", a, e & m, g & m);
		end
	endtask
	task automatic chk_irq(input logic e);
		samples_checked++;
		if (HDLC_IRQ_O !== e) begin
			fails++;
			$display("unexpected irq: expected %b seen %b", e, HDLC_IRQ_O);
		end
	endtask
	task automatic wr(input logic [7:0] a, v);
		WR_I <= 1'b1;
		ADDR_I <= a;
		WDATA_I <= v;
		@(posedge CLK_I);
		WR_I <= 1'b0;
		@(posedge CLK_I);
	endtask
	// Read data is taken one cycle after the strobe
	task automatic rc(input logic [7:0] a, e, m = 8'hff);
		RD_I <= 1'b1;
		ADDR_I <= a;
		@(posedge CLK_I);
		RD_I <= 1'b0;
		@(posedge CLK_I);
		chk_reg(a, e, RDATA_O, m);
	endtask
	// Strobed bits, oldest first
	task automatic bits(input logic [7:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			RX_BIT_STB_I <= 1'b1;
			RX_BIT_I <= v[i];
			@(posedge CLK_I);
		end
		RX_BIT_STB_I <= 1'b0;
		RX_BIT_I <= 1'b0;
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Watchdog, far beyond the about 130 cycles needed
	initial begin
		#20000;
		fails++;
		report_and_stop;
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge CLK_I);
		ARST_N_I <= 1'b1;
		@(posedge CLK_I);
		rc(8'hb2, 8'h00);
		rc(8'hb3, 8'h08);
		rc(8'h10, 8'h00);
		rc(8'hb4, 8'h00);
		TX_NOT_FULL_I <= 1'b1;
		wr(8'hb2, 8'hff);
		rc(8'hb2, 8'h7f);
		chk_irq(1'b1);
		wr(8'hb2, 8'h7d);
		chk_irq(1'b0);
		TX_NOT_FULL_I <= 1'b0;
		TX_MSG_DONE_I <= 1'b1;
		@(posedge CLK_I);
		TX_MSG_DONE_I <= 1'b0;
		rc(8'hb1, 8'h01, 8'h01);
		rc(8'hb1, 8'h00, 8'h01);
		// Live transmit half empty level reaches status and request
		TX_HALF_EMPTY_I <= 1'b1;
		@(posedge CLK_I);
		chk_irq(1'b1);
		rc(8'hb1, 8'h04, 8'h04);
		wr(8'hb2, 8'h7b);
		chk_irq(1'b0);
		TX_HALF_EMPTY_I <= 1'b0;
		// Good three-byte packet, tags follow the head byte
		hdlc_deframer_model_i.send(8'ha1, 3, 1'b1, 1'b0);
		repeat (4) @(posedge CLK_I);
		chk_irq(1'b1);
		rc(8'hb1, 8'h68);
		rc(8'hb3, 8'h11);
		rc(8'hb4, 8'ha1);
		rc(8'hb3, 8'h00);
		rc(8'hb4, 8'ha2);
		rc(8'hb3, 8'h06);
		rc(8'hb4, 8'ha3);
		rc(8'hb3, 8'h08);
		// One-byte packet with a failed check
		hdlc_deframer_model_i.send(8'h5c, 1, 1'b0, 1'b0);
		repeat (4) @(posedge CLK_I);
		rc(8'hb3, 8'h43);
		rc(8'hb4, 8'h5c);
		// Six ones then a zero is no abort, seven is
		bits(8'h3f, 7);
		repeat (4) @(posedge CLK_I);
		rc(8'hb3, 8'h08);
		bits(8'h7f, 7);
		repeat (4) @(posedge CLK_I);
		rc(8'hb3, 8'h88);
		rc(8'hb3, 8'h08);
		rc(8'hb1, 8'h40, 8'h40);
		// Twelve bytes without waiting: ten fit, two are refused
		hdlc_deframer_model_i.send(8'h30, 12, 1'b1, 1'b1);
		repeat (3) @(posedge CLK_I);
		rc(8'hb1, 8'h58, 8'h58);
		rc(8'hb3, 8'h21, 8'h21);
		for (int i = 0; i < 10; i++) begin
			rc(8'hb4, 8'h30 + i[7:0]);
		end
		rc(8'hb3, 8'h08, 8'h08);
		report_and_stop;
	end
endmodule // hdlc_rx_status_tb_top
bind hdlc_rx_status hdlc_rx_status_props hdlc_rx_status_props_i (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
	.ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .RX_BIT_I(RX_BIT_I),
	.RX_BIT_STB_I(RX_BIT_STB_I), .RX_BYTE_VLD_I(RX_BYTE_VLD_I), .RX_BYTE_RDY_O(RX_BYTE_RDY_O),
	.RX_FIRST_I(RX_FIRST_I), .TX_NOT_FULL_I(TX_NOT_FULL_I), .HDLC_IRQ_O(HDLC_IRQ_O));
`default_nettype wire
